/* File: acs_analog_model.sv */
// Purpose: Behavioural analog core for the sequencer bench.
// Assumes: The code encodes the reference and channel seen at the hold pulse.
// Notes: The code is held until the next pulse, like a charged sample capacitor.
`timescale 1ns/1ps
module acs_analog_model (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Sample request and selections
  input wire SAMPLE_HOLD,
  input wire [2:0] CHANNEL_SEL,
  input wire REFERENCE_SEL,
  // Conversion code
  output reg [9:0] ANALOG_RESULT
);
  always @(posedge CLK) begin
    if (RESET) begin
      ANALOG_RESULT <= 10'h000;
    end else if (SAMPLE_HOLD) begin
      ANALOG_RESULT <= {REFERENCE_SEL, CHANNEL_SEL, 6'h15};
    end
  end
endmodule

/* File: acs_consts.vh */
// Purpose: Constants for the converter conversion sequencer.
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite register access.
// Notes: Offsets are byte addresses of one aligned word each.
// Notes on behaviour
// - Writing start bit begins one conversion; bit stays high, hardware clears it.
// - A channel change during conversion applies only after that conversion.
// - With auto trigger on, a rising selected trigger resets prescaler and starts.
// - Trigger still high at completion, or new edges mid-conversion, start nothing.
// - Trigger flags set regardless of interrupt enable; must clear before retriggering.
// - Completion flag as trigger restarts after each completion; first needs start write.
// - Start write still works under auto trigger; start bit reads one while busy.
// - Prescaler counts while enable set, held in reset while enable low.
// - Start-bit conversions begin on next rising converter clock edge.
// - Normal conversion 13 converter cycles; first after enable 25 cycles.
// - Sample-and-hold at 1.5 cycles normal, 13.5 cycles first conversion.
// - Completion stores result, sets flag, clears start bit in single mode.
// - Auto trigger: hold 2 cycles after edge, 13.5 cycles, three sync clocks.
// - Free running restarts after completion with start bit high; 2.5 and 14. Code holds at 2 and converts in 13 cycles.
// - Selections copied continuously, frozen during conversion, resume in last cycle.
// - Free running: channel change after first result shows from second next result.
// - Idle single mode with interrupt enabled: sleep entry starts a conversion.
// - Sleep-started conversion still raises its completion request if CPU woke.
// - Low byte read locks result registers until high byte read; flag still sets.
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_OFS_CTRL_A 8'h00
`define ACS_OFS_CTRL_B 8'h04
`define ACS_OFS_CHREF 8'h08
`define ACS_OFS_RES_LO 8'h0C
`define ACS_OFS_RES_HI 8'h10
`define ACS_OFS_SLEEP 8'h14
`define ACS_A_PS_LSB 0
`define ACS_A_IE 3
`define ACS_A_FLAG 4
`define ACS_A_ATE 5
`define ACS_A_START 6
`define ACS_A_EN 7
`define ACS_B_TS_LSB 0
`define ACS_B_LADJ 4
`define ACS_CH_REF 6
`define ACS_TS_FREE 3'h0
`define ACS_CYC_NORMAL 6'h0D
`define ACS_CYC_FIRST 6'h19
`define ACS_HOLD_NORMAL 6'h01
`define ACS_HOLD_FIRST 6'h0D
`define ACS_SYNC_STAGES 3
`endif

/* File: acs_prescaler.v */
// Purpose: Converter clock prescaler producing one-cycle tick enables.
// Assumes: Cleared synchronously by its clear input.
// Notes: Division 2..128 chosen by the prescaler select field.
`timescale 1ns/1ps
module acs_prescaler (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Control
  input wire clr,
  input wire [2:0] sel,
  // Tick
  output reg tick
);
  reg [6:0] cnt_q;
  wire [6:0] last = (sel == 3'h0) ? 7'h01 : ((7'h01 << sel) - 7'h01);
  always @(posedge CLK) begin
    if (RESET || clr) begin
      cnt_q <= 7'h00;
      tick <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule

/* File: acs_seq_assertions.sv */
// Purpose: Concurrent checks on the sequencer ports.
// Assumes: One clock domain; any prescaler setting.
// Notes: Bounds leave room for half-cycle figures rounded to ticks.
`timescale 1ns/1ps
module acs_seq_assertions (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Bus
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Converter
  input wire SAMPLE_HOLD,
  input wire CONV_ACTIVE,
  input wire [2:0] CHANNEL_SEL,
  input wire REFERENCE_SEL,
  input wire CONV_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  reg [11:0] wait_q;
  reg [5:0] len_q;
  // The slowest prescaler puts the first hold near 1800 clocks, so a counter is used.
  always @(posedge CLK) begin
    if (RESET || !CONV_ACTIVE || SAMPLE_HOLD) wait_q <= 12'h000;
    else if (wait_q != 12'hFFF) wait_q <= wait_q + 12'h001;
    if (RESET || !CONV_ACTIVE) len_q <= 6'h00;
    else if (len_q != 6'h3F) len_q <= len_q + 6'h01;
  end
  sequence s_take;
    S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  endsequence
  sequence s_start;
    s_take ##0 (S_AXI_AWADDR == 8'h00 && S_AXI_WSTRB[0] && S_AXI_WDATA[7:6] == 2'h3);
  endsequence
  property p_bnext; s_take |=> S_AXI_BVALID; endproperty
  a_bnext: assert property (p_bnext) else $error("write response late");
  property p_bstand; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bstand: assert property (p_bstand) else $error("write response dropped");
  property p_rstand; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rstand: assert property (p_rstand) else $error("read response dropped");
  property p_start; s_start |-> ##[1:260] CONV_ACTIVE; endproperty
  a_start: assert property (p_start) else $error("start write gave no conversion");
  property p_hold; SAMPLE_HOLD |-> CONV_ACTIVE ##1 !SAMPLE_HOLD; endproperty
  a_hold: assert property (p_hold) else $error("hold pulse malformed");
  property p_hold_due; wait_q < 12'hE00; endproperty
  a_hold_due: assert property (p_hold_due) else $error("conversion without hold");
  property p_len; $fell(CONV_ACTIVE) |-> len_q >= 6'h18; endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_frozen;
    $rose(CONV_ACTIVE) |-> ##1 ($stable(CHANNEL_SEL) && $stable(REFERENCE_SEL)) [*4];
  endproperty
  a_frozen: assert property (p_frozen) else $error("selection moved in conversion");
  property p_irq; $rose(CONV_IRQ) |-> S_AXI_BVALID || $past(CONV_ACTIVE); endproperty
  a_irq: assert property (p_irq) else $error("flag without completion");
endmodule
bind acs_sequencer acs_seq_assertions u_chk (.CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID,
  .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .SAMPLE_HOLD, .CONV_ACTIVE, .CHANNEL_SEL,
  .REFERENCE_SEL, .CONV_IRQ);

/* File: acs_sequencer.v */
// Purpose: Conversion sequencer of a 10-bit successive-approximation converter.
// Assumes: AXI4-Lite register access; analog core returns a result at completion.
// Notes: Triggers arrive from other clock domains and are synchronised here.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "acs_consts.vh"
module acs_sequencer (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // AXI4-Lite write address and data
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Triggers (bit 0 unused, completion flag is internal)
  input wire [7:0] TRIG_SRC,
  // Sleep and CPU status
  input wire CPU_HALTED,
  // Analog core
  input wire [9:0] ANALOG_RESULT,
  output reg SAMPLE_HOLD,
  output reg CONV_ACTIVE,
  output reg [2:0] CHANNEL_SEL,
  output reg REFERENCE_SEL,
  output wire CONV_IRQ
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  reg [7:0] ctrl_a_q;
  reg [7:0] ctrl_b_q;
  reg [2:0] chan_q;
  reg ref_q;
  reg sleep_q;
  reg [9:0] result_q;
  reg lock_q;
  reg flag_q;
  reg start_q;
  reg first_q;
  reg [2:0] state_q;
  reg [5:0] cyc_q;
  reg [5:0] len_q;
  reg [5:0] hold_q;
  reg halt_d1_q;

  // Bus handshake: a write is taken when both address and data are present.
  wire wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  wire rd_go = S_AXI_ARVALID && !S_AXI_RVALID;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_ARREADY = rd_go;
  wire wr_a = wr_go && S_AXI_WSTRB[0] && (S_AXI_AWADDR == `ACS_OFS_CTRL_A);
  wire en = ctrl_a_q[`ACS_A_EN];
  wire ate = ctrl_a_q[`ACS_A_ATE];
  wire [2:0] ts = ctrl_b_q[`ACS_B_TS_LSB +: 3];
  wire start_wr = wr_a && S_AXI_WDATA[`ACS_A_START] && S_AXI_WDATA[`ACS_A_EN];

  // Trigger synchroniser: three stages, a change counts once stages two and three agree.
  reg [7:0] t1_q;
  reg [7:0] t2_q;
  reg [7:0] t3_q;
  reg [7:0] tf_q;
  // A level is accepted only when stages two and three agree, so a metastable
  // first stage can never produce a false edge.
  wire [7:0] t_agree = ~(t2_q ^ t3_q);
  always @(posedge CLK) begin
    if (RESET) begin
      t1_q <= 8'h00;
      t2_q <= 8'h00;
      t3_q <= 8'h00;
      tf_q <= 8'h00;
    end else begin
      t1_q <= TRIG_SRC;
      t2_q <= t1_q;
      t3_q <= t2_q;
      tf_q <= (t_agree & t3_q) | (~t_agree & tf_q);
    end
  end
  wire trig_rise = t3_q[ts] && t2_q[ts] && !tf_q[ts];

  wire busy = (state_q != ST_IDLE);
  wire auto_go = en && ate && !busy && trig_rise && (ts != `ACS_TS_FREE);
  wire tick;
  acs_prescaler u_pre (
    .CLK(CLK),
    .RESET(RESET),
    .clr(!en || auto_go),
    .sel(ctrl_a_q[`ACS_A_PS_LSB +: 3]),
    .tick(tick)
  );

  wire halt_rise = CPU_HALTED && !halt_d1_q;
  wire sleep_go = en && !busy && !ate && ctrl_a_q[`ACS_A_IE] && sleep_q && halt_rise;
  wire done = (state_q == ST_CONV) && tick && (cyc_q == len_q - 6'h01);
  wire free_run = ate && (ts == `ACS_TS_FREE);
  wire lo_read = rd_go && (S_AXI_ARADDR == `ACS_OFS_RES_LO);
  wire hi_read = rd_go && (S_AXI_ARADDR == `ACS_OFS_RES_HI);

  // Sequencer.
  always @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      cyc_q <= 6'h00;
      len_q <= `ACS_CYC_NORMAL;
      hold_q <= `ACS_HOLD_NORMAL;
      start_q <= 1'b0;
      first_q <= 1'b1;
      flag_q <= 1'b0;
      result_q <= 10'h000;
      lock_q <= 1'b0;
      SAMPLE_HOLD <= 1'b0;
      halt_d1_q <= 1'b0;
    end else begin
      halt_d1_q <= CPU_HALTED;
      SAMPLE_HOLD <= 1'b0;
      if (!en) begin
        first_q <= 1'b1;
        state_q <= ST_IDLE;
        start_q <= 1'b0;
      end
      if (hi_read) begin
        lock_q <= 1'b0;
      end else if (lo_read) begin
        lock_q <= 1'b1;
      end
      if (wr_a && S_AXI_WDATA[`ACS_A_FLAG]) begin
        flag_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (start_wr || sleep_go) begin
            state_q <= ST_WAIT;
            start_q <= 1'b1;
          end else if (auto_go) begin
            state_q <= ST_CONV;
            start_q <= 1'b1;
            cyc_q <= 6'h00;
            len_q <= first_q ? `ACS_CYC_FIRST : `ACS_CYC_NORMAL;
            hold_q <= first_q ? `ACS_HOLD_FIRST : `ACS_HOLD_NORMAL;
          end
        end
        ST_WAIT: begin
          if (en && tick) begin
            state_q <= ST_CONV;
            cyc_q <= 6'h00;
            len_q <= first_q ? `ACS_CYC_FIRST : `ACS_CYC_NORMAL;
            hold_q <= first_q ? `ACS_HOLD_FIRST : `ACS_HOLD_NORMAL;
          end
        end
        ST_CONV: begin
          if (tick) begin
            cyc_q <= cyc_q + 6'h01;
            if (cyc_q == hold_q) begin
              SAMPLE_HOLD <= 1'b1;
            end
            if (done) begin
              first_q <= 1'b0;
              flag_q <= 1'b1;
              if (!lock_q) begin
                result_q <= ANALOG_RESULT;
              end
              if (free_run) begin
                cyc_q <= 6'h00;
                len_q <= `ACS_CYC_NORMAL;
                hold_q <= `ACS_HOLD_NORMAL;
              end else begin
                state_q <= ST_IDLE;
                start_q <= 1'b0;
              end
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Selection buffer: frozen while converting, copying resumes in last cycle.
  always @(posedge CLK) begin
    if (RESET) begin
      CHANNEL_SEL <= 3'h0;
      REFERENCE_SEL <= 1'b0;
      CONV_ACTIVE <= 1'b0;
    end else begin
      CONV_ACTIVE <= (state_q == ST_CONV);
      if (state_q != ST_CONV || cyc_q == len_q - 6'h01) begin
        CHANNEL_SEL <= chan_q;
        REFERENCE_SEL <= ref_q;
      end
    end
  end

  // Register writes.
  always @(posedge CLK) begin
    if (RESET) begin
      ctrl_a_q <= 8'h00;
      ctrl_b_q <= 8'h00;
      chan_q <= 3'h0;
      ref_q <= 1'b0;
      sleep_q <= 1'b0;
    end else if (wr_go && S_AXI_WSTRB[0]) begin
      if (S_AXI_AWADDR == `ACS_OFS_CTRL_A) begin
        ctrl_a_q <= S_AXI_WDATA[7:0] & 8'hAF;
      end else if (S_AXI_AWADDR == `ACS_OFS_CTRL_B) begin
        ctrl_b_q <= S_AXI_WDATA[7:0] & 8'h17;
      end else if (S_AXI_AWADDR == `ACS_OFS_CHREF) begin
        chan_q <= S_AXI_WDATA[2:0];
        ref_q <= S_AXI_WDATA[`ACS_CH_REF];
      end else if (S_AXI_AWADDR == `ACS_OFS_SLEEP) begin
        sleep_q <= S_AXI_WDATA[0];
      end
    end
  end

  // Write response.
  always @(posedge CLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (S_AXI_AWADDR <= `ACS_OFS_SLEEP && S_AXI_AWADDR[1:0] == 2'b00) ?
                     2'b00 : 2'b10;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Left adjust shifts the 10-bit result to the top of 16 bits.
  wire [15:0] res16 = ctrl_b_q[`ACS_B_LADJ] ? {result_q, 6'h00} : {6'h00, result_q};

  // Read data.
  always @(posedge CLK) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= 2'b00;
    end else if (rd_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= 2'b00;
      if (S_AXI_ARADDR == `ACS_OFS_CTRL_A) begin
        S_AXI_RDATA <= {24'h000000, ctrl_a_q[7], start_q, ctrl_a_q[5], flag_q,
                        ctrl_a_q[3:0]};
      end else if (S_AXI_ARADDR == `ACS_OFS_CTRL_B) begin
        S_AXI_RDATA <= {24'h000000, ctrl_b_q};
      end else if (S_AXI_ARADDR == `ACS_OFS_CHREF) begin
        S_AXI_RDATA <= {24'h000000, 1'b0, ref_q, 3'h0, chan_q};
      end else if (S_AXI_ARADDR == `ACS_OFS_RES_LO) begin
        S_AXI_RDATA <= {24'h000000, res16[7:0]};
      end else if (S_AXI_ARADDR == `ACS_OFS_RES_HI) begin
        S_AXI_RDATA <= {24'h000000, res16[15:8]};
      end else if (S_AXI_ARADDR == `ACS_OFS_SLEEP) begin
        S_AXI_RDATA <= {31'h00000000, sleep_q};
      end else begin
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= 2'b10;
      end
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Completion request to the CPU, gated by the interrupt enable.
  assign CONV_IRQ = flag_q && ctrl_a_q[`ACS_A_IE];
endmodule

/* File: acs_sequencer_bench.sv */
// Purpose: Register-level bench for the conversion sequencer.
// Assumes: Prescaler kept at divide by two, so one tick is two clocks.
// Notes: Lengths get a small margin because half ticks are rounded.
`timescale 1ns/1ps
module acs_sequencer_bench;
  reg CLK = 1'h0, RESET = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0;
  reg rry = 1'h0, halt = 1'h0;
  reg [7:0] aw = 8'h00, ar = 8'h00, trig = 8'h00;
  reg [31:0] wd = 32'h0, v, lo;
  reg [1:0] resp;
  wire awr, wrr, bv, arr, rv, sh, act, rf, irq;
  wire [1:0] br, rr;
  wire [31:0] rdd;
  wire [2:0] ch;
  wire [9:0] res;
  integer bad_count = 0, samples_checked = 0, holds = 0, run = 0, n = 0, h0;
  acs_sequencer dut (.CLK(CLK), .RESET(RESET), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .TRIG_SRC(trig),
    .CPU_HALTED(halt), .ANALOG_RESULT(res), .SAMPLE_HOLD(sh), .CONV_ACTIVE(act),
    .CHANNEL_SEL(ch), .REFERENCE_SEL(rf), .CONV_IRQ(irq));
  acs_analog_model core (.CLK(CLK), .RESET(RESET), .SAMPLE_HOLD(sh), .CHANNEL_SEL(ch),
    .REFERENCE_SEL(rf), .ANALOG_RESULT(res));
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (sh === 1'h1) holds <= holds + 1;
    if (act === 1'h1) run <= run + 1;
    else if (run != 0) begin
      n <= run;
      run <= 0;
    end
  end
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      aw <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      @(posedge CLK);
      while (!(awr === 1'h1 && wrr === 1'h1)) @(posedge CLK);
      awv <= 1'h0;
      wv <= 1'h0;
      bry <= 1'h1;
      @(posedge CLK);
      while (bv !== 1'h1) @(posedge CLK);
      resp = br;
      bry <= 1'h0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge CLK);
      ar <= a;
      arv <= 1'h1;
      @(posedge CLK);
      while (arr !== 1'h1) @(posedge CLK);
      arv <= 1'h0;
      rry <= 1'h1;
      @(posedge CLK);
      while (rv !== 1'h1) @(posedge CLK);
      v = rdd;
      resp = rr;
      rry <= 1'h0;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task conv;
    begin
      while (act !== 1'h1) @(posedge CLK);
      while (act === 1'h1) @(posedge CLK);
      @(posedge CLK);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // The tests need about 700 clocks; the limit leaves a wide margin.
  initial begin
    #150000;
    bad_count = bad_count + 1;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 1'h0;
    rd(8'h00);
    chk("ctrl reset", v, 32'h0);
    rd(8'h20);
    chk("unmapped", resp, 2'h2);
    wr(8'h08, 32'h45);
    chk("write resp", resp, 2'h0);
    wr(8'h00, 32'hC8);
    rd(8'h00);
    chk("start busy", v[6], 1'h1);
    conv;
    chk("first len", n >= 48 && n <= 52, 1'h1);
    rd(8'h00);
    chk("start clear", v[6], 1'h0);
    chk("irq", irq, 1'h1);
    rd(8'h0C);
    lo = v;
    rd(8'h10);
    chk("result", {v[1:0], lo[7:0]}, 10'h355);
    wr(8'h00, 32'hD8);
    repeat (4) @(posedge CLK);
    wr(8'h08, 32'h02);
    chk("sel frozen", {rf, ch}, 4'hD);
    conv;
    chk("normal len", n >= 24 && n <= 28, 1'h1);
    chk("sel applied", {rf, ch}, 4'h2);
    rd(8'h0C);
    chk("old channel", v[7:0], 8'h55);
    wr(8'h00, 32'hD8);
    conv;
    chk("flag locked", irq, 1'h1);
    rd(8'h10);
    chk("locked high", v[1:0], 2'h3);
    wr(8'h04, 32'h2);
    wr(8'h00, 32'hB8);
    h0 = holds;
    trig[2] <= 1'h1;
    repeat (12) @(posedge CLK);
    trig[2] <= 1'h0;
    repeat (4) @(posedge CLK);
    trig[2] <= 1'h1;
    repeat (80) @(posedge CLK);
    chk("one trigger", holds - h0, 1);
    trig[2] <= 1'h0;
    repeat (8) @(posedge CLK);
    trig[2] <= 1'h1;
    repeat (60) @(posedge CLK);
    chk("next trigger", holds - h0, 2);
    wr(8'h00, 32'hF8);
    conv;
    chk("start in auto", holds - h0, 3);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hF8);
    h0 = holds;
    repeat (100) @(posedge CLK);
    chk("free running", holds - h0 >= 3, 1'h1);
    rd(8'h00);
    chk("start held", v[6], 1'h1);
    // Leave free running first so the last conversion runs to its full length.
    wr(8'h00, 32'h88);
    conv;
    wr(8'h00, 32'h10);
    repeat (40) @(posedge CLK);
    h0 = holds;
    repeat (60) @(posedge CLK);
    chk("disabled", holds, h0);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h88);
    h0 = holds;
    halt <= 1'h1;
    repeat (10) @(posedge CLK);
    halt <= 1'h0;
    repeat (70) @(posedge CLK);
    chk("sleep start", holds - h0, 1);
    chk("sleep irq", irq, 1'h1);
    end_sim;
  end
endmodule
